// [hdl/gtm_timer.sv]
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
// What this block does
// - clock source field picks low-freq osc, pin/oscillator, system clock or instruction clock
// - pin/oscillator source uses external clock or secondary oscillator per request bit
// - prescale field divides the input clock by 1, 2, 4 or 8
// - external source is always synchronised; sync-disable is stored but has no effect
// - internal sources ignore sync-disable and get no extra stage
// - timer_on enables counting; clearing it stops counting and clears toggle flop
// - gate enable ignored when off; otherwise gate controls counting
// - gate polarity picks whether high or low gate level counts
// - toggle mode toggles gate flop on rising gate edges, else held cleared
// - single-pulse mode bit hands the gate to single-pulse acquisition
// - software arms acquisition; hardware clears armed bit when acquisition completes
// - clearing single-pulse mode also clears the armed bit
// - read-only gate level bit, sampled at Q1, same signal gating the counter
// - gate source field picks comparator 2, comparator 1, Timer0 overflow or pin
// - with pin/oscillator or low-freq osc source, a falling clock edge must be seen before the first counted rising edge
// - count readable and writable as low and high bytes
// - control bits reset to zero; unimplemented bit reads zero
// - single pulse enables on active gate level once armed, ends on trailing edge
// - count wraps FFFF to 0000 and sets the rollover flag
// - falling gate level sets the gate event flag even with gate disabled
module gtm_timer (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous sources
    input wire gtm_pkg::gtm_inputs_t sources,
    // event flags
    output logic rollover_flag,
    output logic gate_event_flag
);

    gtm_pkg::gtm_state_t state;
    gtm_pkg::gtm_state_t next_state;

    // read mux, shared by the bus logic
    function automatic logic [31:0] read_word(input gtm_pkg::gtm_state_t s, input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            gtm_pkg::ADDR_TIMER_CONTROL: w[7:0] = s.timer_control & gtm_pkg::TC_WMASK;
            gtm_pkg::ADDR_GATE_CONTROL: w[7:0] = s.gate_control;
            gtm_pkg::ADDR_COUNT_LOW: w[7:0] = s.count[7:0];
            gtm_pkg::ADDR_COUNT_HIGH: w[7:0] = s.count[15:8];
            gtm_pkg::ADDR_FLAGS: w[1:0] = {s.gate_event_flag, s.rollover_flag};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return a == gtm_pkg::ADDR_TIMER_CONTROL || a == gtm_pkg::ADDR_GATE_CONTROL
            || a == gtm_pkg::ADDR_COUNT_LOW || a == gtm_pkg::ADDR_COUNT_HIGH
            || a == gtm_pkg::ADDR_FLAGS;
    endfunction

    logic [1:0] cs;
    logic [1:0] ps_sel;
    logic timer_on;
    logic clk_src;
    logic tick;
    logic ps_pulse;
    logic [2:0] ps_next;
    logic gate_raw;
    logic gate_pol;
    logic gate_rise;
    logic gate_fall;
    logic toggle_next;
    logic gate_tm;
    logic gate_eff;
    logic level_now;
    logic count_en;
    logic acc_wr;
    logic acc_rd;
    logic armed_clr;
    logic [16:0] count_inc;

    always_comb
    begin
        next_state = state;
        cs = state.timer_control[gtm_pkg::TC_CS_LO +: 2];
        ps_sel = state.timer_control[gtm_pkg::TC_PS_LO +: 2];
        timer_on = state.timer_control[gtm_pkg::TC_ON];

        // two-flop synchronisers for every outside input
        next_state.sync1 = sources;
        next_state.sync2 = state.sync1;
        next_state.qphase = state.qphase + 2'h1;

        // external stage always passes the two flops since logic here
        // is fully synchronous; sync_disable is stored but an unsynchronised path is not offered
        clk_src = 1'b0;
        tick = 1'b0;
        unique case (cs)
            gtm_pkg::CS_INSTR: tick = state.qphase == gtm_pkg::QPHASE_LAST;
            gtm_pkg::CS_SYS: tick = 1'b1;
            gtm_pkg::CS_EXT:
            begin
                clk_src = state.timer_control[gtm_pkg::TC_SECONDARY_OSCILLATOR] ? state.sync2.secondary_oscillator : state.sync2.ext_clock;
            end
            gtm_pkg::CS_LFOSC: clk_src = state.sync2.lfosc;
        endcase
        next_state.clk_prev = clk_src;
        // arm rising-edge counting only after a falling edge
        if (cs[1] && state.clk_prev && !clk_src)
        begin
            next_state.fall_seen = 1'b1;
        end
        if (cs[1])
        begin
            tick = state.fall_seen && !state.clk_prev && clk_src;
        end

        // prescaler, output pulse when the low bits wrap
        ps_next = state.prescale + {2'b00, tick};
        ps_pulse = 1'b0;
        unique case (ps_sel)
            2'h0: ps_pulse = tick;
            2'h1: ps_pulse = tick && state.prescale[0];
            2'h2: ps_pulse = tick && (state.prescale[1:0] == 2'h3);
            2'h3: ps_pulse = tick && (state.prescale == 3'h7);
        endcase
        next_state.prescale = ps_next;

        unique case (state.gate_control[gtm_pkg::GC_SS_LO +: 2])
            gtm_pkg::GS_PIN: gate_raw = state.sync2.gate_pin;
            gtm_pkg::GS_T0: gate_raw = state.sync2.t0_overflow;
            gtm_pkg::GS_CMP1: gate_raw = state.sync2.cmp1;
            gtm_pkg::GS_CMP2: gate_raw = state.sync2.cmp2;
        endcase
        gate_pol = gate_raw ~^ state.gate_control[gtm_pkg::GC_POL];
        next_state.gate_prev = gate_pol;
        gate_rise = gate_pol && !state.gate_prev;

        // toggle flop, cleared while timer off
        toggle_next = state.toggle_ff;
        if (!state.gate_control[gtm_pkg::GC_TM] || !timer_on)
        begin
            toggle_next = 1'b0;
        end
        else if (gate_rise)
        begin
            toggle_next = !state.toggle_ff;
        end
        next_state.toggle_ff = toggle_next;
        gate_tm = state.gate_control[gtm_pkg::GC_TM] ? state.toggle_ff : gate_pol;

        // single pulse opens on active gate level while armed, closes on trailing edge
        armed_clr = 1'b0;
        if (state.gate_control[gtm_pkg::GC_SPM])
        begin
            if (state.gate_control[gtm_pkg::GC_ARMED] && !state.spm_open && gate_tm)
            begin
                next_state.spm_open = 1'b1;
            end
            if (state.spm_open && !gate_tm)
            begin
                next_state.spm_open = 1'b0;
                armed_clr = 1'b1;
            end
            gate_eff = state.spm_open && gate_tm;
        end
        else
        begin
            next_state.spm_open = 1'b0;
            gate_eff = gate_tm;
        end

        // gate level latched at Q1, same value that gates the counter
        level_now = state.gate_control[gtm_pkg::GC_LEVEL];
        if (state.qphase == gtm_pkg::QPHASE_Q1)
        begin
            level_now = gate_eff;
        end
        next_state.gate_control[gtm_pkg::GC_LEVEL] = level_now;
        next_state.level_prev = state.gate_control[gtm_pkg::GC_LEVEL];
        // falling gate level, independent of gate enable
        gate_fall = state.level_prev && !state.gate_control[gtm_pkg::GC_LEVEL];

        count_en = timer_on && ps_pulse
            && (!state.gate_control[gtm_pkg::GC_EN] || state.gate_control[gtm_pkg::GC_LEVEL]);
        count_inc = {1'b0, state.count} + 17'h0_0001;
        if (count_en)
        begin
            next_state.count = count_inc[15:0];
        end

        // apb access phase takes two cycles: the registered answer adds one wait state
        acc_wr = psel && penable && pwrite && !state.rsp.pready;
        acc_rd = psel && penable && !pwrite && !state.rsp.pready;
        next_state.rsp.pready = psel && penable && !state.rsp.pready;
        next_state.rsp.pslverr = psel && penable && !state.rsp.pready && !is_mapped(paddr);
        next_state.rsp.prdata = acc_rd ? read_word(state, paddr) : 32'h0000_0000;

        // wrap and gate event flags; for each, set wins over a clear in the same cycle
        if (acc_wr && paddr == gtm_pkg::ADDR_FLAGS)
        begin
            if (pwdata[gtm_pkg::FL_ROLL])
            begin
                next_state.rollover_flag = 1'b0;
            end
            if (pwdata[gtm_pkg::FL_GATE])
            begin
                next_state.gate_event_flag = 1'b0;
            end
        end
        if (count_en && state.count == gtm_pkg::COUNT_MAX)
        begin
            next_state.rollover_flag = 1'b1;
        end
        if (gate_fall)
        begin
            next_state.gate_event_flag = 1'b1;
        end

        // register writes; a software write to a count byte wins over the increment of that byte only
        if (acc_wr)
        begin
            unique case (paddr)
                gtm_pkg::ADDR_TIMER_CONTROL: next_state.timer_control = pwdata[7:0] & gtm_pkg::TC_WMASK;
                gtm_pkg::ADDR_GATE_CONTROL:
                begin
                    next_state.gate_control = (pwdata[7:0] & gtm_pkg::GC_WMASK)
                        | {4'h0, pwdata[gtm_pkg::GC_ARMED], level_now, 2'h0};
                end
                gtm_pkg::ADDR_COUNT_LOW: next_state.count[7:0] = pwdata[7:0];
                gtm_pkg::ADDR_COUNT_HIGH: next_state.count[15:8] = pwdata[7:0];
                default: next_state.count = next_state.count;
            endcase
        end
        // hardware clear of the armed bit
        if (armed_clr)
        begin
            next_state.gate_control[gtm_pkg::GC_ARMED] = 1'b0;
        end
        // leaving single-pulse mode drops the armed bit
        if (!next_state.gate_control[gtm_pkg::GC_SPM])
        begin
            next_state.gate_control[gtm_pkg::GC_ARMED] = 1'b0;
        end
        // clock source change restarts the falling-edge qualification
        if (!next_state.timer_control[gtm_pkg::TC_CS_LO + 1]
            || next_state.timer_control != state.timer_control)
        begin
            next_state.fall_seen = 1'b0;
        end
    end

    // state register; the count has no documented reset, zero is used for a clean start
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state <= '0;
            state.timer_control <= gtm_pkg::TC_RESET;
            state.gate_control <= gtm_pkg::GC_RESET;
            state.count <= gtm_pkg::COUNT_RESET;
            state.prescale <= gtm_pkg::PS_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign prdata = state.rsp.prdata;
    assign pready = state.rsp.pready;
    assign pslverr = state.rsp.pslverr;
    assign rollover_flag = state.rollover_flag;
    assign gate_event_flag = state.gate_event_flag;

endmodule

// [hdl/gtm_pkg.sv]
package gtm_pkg;

    // register byte addresses (word aligned)
    localparam logic [11:0] ADDR_TIMER_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_GATE_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_COUNT_LOW = 12'h008;
    localparam logic [11:0] ADDR_COUNT_HIGH = 12'h00C;
    localparam logic [11:0] ADDR_FLAGS = 12'h010;

    // timer_control field positions
    localparam int TC_ON = 0;
    localparam int TC_SYNC_DIS = 2;
    localparam int TC_SECONDARY_OSCILLATOR = 3;
    localparam int TC_PS_LO = 4;
    localparam int TC_CS_LO = 6;
    // gate_control field positions
    localparam int GC_SS_LO = 0;
    localparam int GC_LEVEL = 2;
    localparam int GC_ARMED = 3;
    localparam int GC_SPM = 4;
    localparam int GC_TM = 5;
    localparam int GC_POL = 6;
    localparam int GC_EN = 7;
    // flags register field positions (write one to clear)
    localparam int FL_ROLL = 0;
    localparam int FL_GATE = 1;

    // reset values and masks
    localparam logic [7:0] TC_RESET = 8'h00;
    localparam logic [7:0] GC_RESET = 8'h00;
    localparam logic [7:0] TC_WMASK = 8'hFD;
    localparam logic [7:0] GC_WMASK = 8'hF3;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [2:0] PS_RESET = 3'h0;

    // clock source codes
    localparam logic [1:0] CS_INSTR = 2'h0;
    localparam logic [1:0] CS_SYS = 2'h1;
    localparam logic [1:0] CS_EXT = 2'h2;
    localparam logic [1:0] CS_LFOSC = 2'h3;
    // gate source codes
    localparam logic [1:0] GS_PIN = 2'h0;
    localparam logic [1:0] GS_T0 = 2'h1;
    localparam logic [1:0] GS_CMP1 = 2'h2;
    localparam logic [1:0] GS_CMP2 = 2'h3;

    // instruction clock is system clock divided by four
    localparam logic [1:0] QPHASE_LAST = 2'h3;
    localparam logic [1:0] QPHASE_Q1 = 2'h0;

    // external asynchronous inputs
    typedef struct packed {
        logic ext_clock;
        logic secondary_oscillator;
        logic lfosc;
        logic gate_pin;
        logic t0_overflow;
        logic cmp1;
        logic cmp2;
    } gtm_inputs_t;

    // apb slave answer
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } gtm_apb_rsp_t;

    // whole module state
    typedef struct packed {
        gtm_inputs_t sync1;
        gtm_inputs_t sync2;
        logic [7:0] timer_control;
        logic [7:0] gate_control;
        logic [15:0] count;
        logic [1:0] qphase;
        logic clk_prev;
        logic fall_seen;
        logic [2:0] prescale;
        logic toggle_ff;
        logic gate_prev;
        logic spm_open;
        logic level_prev;
        logic rollover_flag;
        logic gate_event_flag;
        gtm_apb_rsp_t rsp;
    } gtm_state_t;

endpackage

// [tb/gtm_timer_chk.sv]
`timescale 1ns/100ps
module gtm_chk (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sources and flags
    input wire gtm_pkg::gtm_inputs_t sources,
    input wire logic rollover_flag,
    input wire logic gate_event_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic acc;
    logic wfl;
    // access edge, and a flags write that may clear a flag there
    assign acc = psel && penable && !pready;
    assign wfl = acc && pwrite && paddr == gtm_pkg::ADDR_FLAGS;
    answer_one_a: assert property (acc |=> pready)
        else $error("no answer one cycle after access");
    pulse_one_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    unmapped_a: assert property (pready && paddr > gtm_pkg::ADDR_FLAGS |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && paddr <= gtm_pkg::ADDR_FLAGS |-> !pslverr)
        else $error("mapped access refused");
    ctrl_resv_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 0 && !prdata[1])
        else $error("reserved control bits read nonzero");
    roll_hold_a: assert property (rollover_flag && !(wfl && pwdata[0]) |=> rollover_flag)
        else $error("rollover flag lost");
    gate_hold_a: assert property (gate_event_flag && !(wfl && pwdata[1]) |=> gate_event_flag)
        else $error("gate event flag lost");
    cover property (pslverr);
    cover property ($rose(rollover_flag));
    cover property ($rose(gate_event_flag));
endmodule

bind gtm_timer gtm_chk chk (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sources(sources),
    .rollover_flag(rollover_flag), .gate_event_flag(gate_event_flag));

// [tb/gtm_far_model.sv]
`timescale 1ns/100ps
module gtm_far_model (
    // clock
    input wire logic clock,
    // levels asked by the bench
    input wire logic gate_lvl,
    input wire logic [1:0] cmp_lvl,
    // source bundle
    output gtm_pkg::gtm_inputs_t sources
);
    logic [5:0] cnt = 6'h00;
    // free running pin clock and oscillators: periods 16, 32 and 64 cycles
    always_ff @(posedge clock)
        cnt <= cnt + 6'h01;
    // no timer0 model, so its overflow idles low
    assign sources = '{ext_clock: cnt[3], secondary_oscillator: cnt[4], lfosc: cnt[5], gate_pin: gate_lvl,
        t0_overflow: 1'h0, cmp1: cmp_lvl[0], cmp2: cmp_lvl[1]};
endmodule

// [tb/gtm_timer_tb.sv]
`timescale 1ns/100ps
module gtm_timer_tb;
    logic clock;
    logic reset = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic rollover_flag;
    logic gate_event_flag;
    logic gate_lvl = 1'h0;
    logic [1:0] cmp_lvl = 2'h1;
    logic [15:0] c;
    gtm_pkg::gtm_inputs_t sources;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    // counting cases: control value with timer off, count expected over a 402 cycle window
    typedef struct {logic [7:0] tc; int exp;} gtm_row_t;
    gtm_row_t rows[10] = '{'{8'h40, 402}, '{8'h44, 402}, '{8'h70, 50}, '{8'h00, 100}, '{8'h10, 50},
        '{8'h20, 25}, '{8'h80, 25}, '{8'h88, 12}, '{8'hC0, 6}, '{8'h84, 25}};

    gtm_timer uut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sources(sources), .rollover_flag(rollover_flag), .gate_event_flag(gate_event_flag));
    gtm_far_model far (.clock(clock), .gate_lvl(gate_lvl), .cmp_lvl(cmp_lvl), .sources(sources));

    // 125 MHz clock
    initial
    begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    // hang guard, well above the expected run length
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            $display("ERROR %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'h1)
        begin
            n_fail++;
            $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // one apb transfer, entered just after an edge; an idle cycle follows so psel is never set twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1 && n < 50)
        begin
            n++;
            @(posedge clock);
        end
        // a slave that never answers is a mismatch, not a silent pass
        if (pready !== 1'h1)
        begin
            n_fail++;
            $display("ERROR %0t no apb answer", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask

    // load count, run n cycles toggling the gate every p cycles, stop and read the count
    task automatic run(input logic [7:0] tc, input int n, input int p, input logic [15:0] s);
        int k = 0;
        apb(1'h1, gtm_pkg::ADDR_COUNT_LOW, s[7:0]);
        apb(1'h1, gtm_pkg::ADDR_COUNT_HIGH, s[15:8]);
        apb(1'h1, gtm_pkg::ADDR_TIMER_CONTROL, tc | 8'h01);
        repeat (n)
        begin
            @(posedge clock);
            k++;
            if (p > 0 && k % p == 0)
                gate_lvl <= !gate_lvl;
        end
        apb(1'h1, gtm_pkg::ADDR_TIMER_CONTROL, tc);
        apb(1'h0, gtm_pkg::ADDR_COUNT_LOW, 8'h00);
        c[7:0] = rd[7:0];
        apb(1'h0, gtm_pkg::ADDR_COUNT_HIGH, 8'h00);
        c[15:8] = rd[7:0];
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        foreach (rows[i])
        begin
            run(rows[i].tc, 400, 0, 16'h0000);
            chk_rng(c, rows[i].exp - 4, rows[i].exp + 4);
        end
        $display("clock source cases done");
        apb(1'h1, gtm_pkg::ADDR_TIMER_CONTROL, 8'hFF);
        apb(1'h0, gtm_pkg::ADDR_TIMER_CONTROL, 8'h00);
        chk(rd, 32'h0000_00FD);
        reset <= 1'h1;
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        apb(1'h0, gtm_pkg::ADDR_TIMER_CONTROL, 8'h00);
        chk(rd, 32'h0000_0000);
        apb(1'h0, gtm_pkg::ADDR_GATE_CONTROL, 8'h00);
        chk(rd & 32'hFFFF_FFFB, 32'h0000_0000);
        apb(1'h1, gtm_pkg::ADDR_COUNT_LOW, 8'hA5);
        apb(1'h1, gtm_pkg::ADDR_COUNT_HIGH, 8'h5A);
        apb(1'h0, gtm_pkg::ADDR_COUNT_LOW, 8'h00);
        chk(rd, 32'h0000_00A5);
        apb(1'h0, gtm_pkg::ADDR_COUNT_HIGH, 8'h00);
        chk(rd, 32'h0000_005A);
        apb(1'h0, 12'h014, 8'h00);
        chk({rd[30:0], err}, 32'h0000_0001);
        $display("reset and register test done");
        apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'hC0);
        run(8'h40, 100, 0, 16'h0000);
        chk(32'(c), 32'h0000_0000);
        gate_lvl <= 1'h1;
        run(8'h40, 100, 0, 16'h0000);
        chk_rng(c, 98, 106);
        apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'h80);
        run(8'h40, 100, 0, 16'h0000);
        chk(32'(c), 32'h0000_0000);
        for (int s = 0; s < 4; s++)
        begin
            apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'h40 | 8'(s));
            repeat (8) @(posedge clock);
            apb(1'h0, gtm_pkg::ADDR_GATE_CONTROL, 8'h00);
            chk(32'(rd[2]), 32'((s + 1) % 2));
        end
        apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'h40);
        apb(1'h1, gtm_pkg::ADDR_FLAGS, 8'h03);
        gate_lvl <= 1'h0;
        repeat (10) @(posedge clock);
        chk(32'(gate_event_flag), 32'h0000_0001);
        apb(1'h1, gtm_pkg::ADDR_FLAGS, 8'h02);
        chk(32'(gate_event_flag), 32'h0000_0000);
        $display("gate level test done");
        apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'hE0);
        run(8'h40, 100, 40, 16'h0000);
        chk_rng(c, 56, 68);
        run(8'h40, 100, 0, 16'h0000);
        chk(32'(c), 32'h0000_0000);
        gate_lvl <= 1'h0;
        apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'hD8);
        apb(1'h0, gtm_pkg::ADDR_GATE_CONTROL, 8'h00);
        chk(32'(rd[3]), 32'h0000_0001);
        run(8'h40, 100, 20, 16'h0000);
        chk_rng(c, 16, 24);
        apb(1'h0, gtm_pkg::ADDR_GATE_CONTROL, 8'h00);
        chk(32'(rd[3]), 32'h0000_0000);
        apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'hD8);
        apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'hC8);
        apb(1'h0, gtm_pkg::ADDR_GATE_CONTROL, 8'h00);
        chk(32'(rd[3]), 32'h0000_0000);
        $display("toggle and single pulse test done");
        apb(1'h1, gtm_pkg::ADDR_GATE_CONTROL, 8'h00);
        apb(1'h1, gtm_pkg::ADDR_FLAGS, 8'h03);
        run(8'h40, 40, 0, 16'hFFF0);
        chk_rng(c, 16, 32);
        chk(32'(rollover_flag), 32'h0000_0001);
        apb(1'h1, gtm_pkg::ADDR_FLAGS, 8'h01);
        chk(32'(rollover_flag), 32'h0000_0000);
        $display("rollover test done");
        tally_and_finish();
    end
endmodule
